// ### common/prwk_pkg.sv
// Package: register map, field positions, timing and carrier types
package prwk_pkg;
  localparam logic [7:0] PRWK_OFS_CTRL = 8'h00;
  localparam int PRWK_BIT_CAUSE0 = 0;
  localparam int PRWK_BIT_CAUSE1 = 1;
  localparam int PRWK_BIT_PHYWK = 2;
  localparam int PRWK_BIT_LANWK = 3;
  localparam int PRWK_BIT_PRST = 4;
  localparam int PRWK_BIT_READY = 7;
  localparam int PRWK_BIT_CLRE = 8;
  localparam int PRWK_BIT_CLRS = 9;
  localparam int PRWK_BIT_EEE = 12;
  localparam logic PRWK_RST_CLRE = 1'b1;
  localparam logic PRWK_RST_CLRS = 1'b0;
  localparam logic [1:0] PRWK_SUSP0 = 2'h0;
  localparam logic [1:0] PRWK_SUSP3 = 2'h3;
  localparam int PRWK_CLK_MHZ = 100;
  localparam int PRWK_RST_MS = 4;
  localparam int PRWK_RST_CYC = PRWK_RST_MS * 1000 * PRWK_CLK_MHZ;
  localparam int PRWK_CNT_W = 23;

  typedef enum {PRWK_IDLE, PRWK_HOLD} prwk_ph_t;

  typedef struct packed {
    logic [1:0]  cause;
    logic        eee;
    logic        lan_en;
    logic        phy_en;
    logic        clr_en;
    logic        clr_sts;
    logic        prst;
    logic [PRWK_CNT_W-1:0] cnt;
    logic        ready;
    logic        pin_low;
    logic        ack;
    logic [31:0] dat;
  } prwk_st_t;
endpackage

// ### rtl/prwk_ctl.sv
// Phy reset, ready and wake status control slice with Wishbone slave
`timescale 1ns/1ps
`default_nettype none
module prwk_ctl
  import prwk_pkg::*;
#(
  parameter int RST_CYC = PRWK_RST_CYC
) (
  // Clock and reset
  input  wire logic        CLK_SYS,
  input  wire logic        SRST,
  // Wishbone slave
  input  wire logic        WB_CYC_I,
  input  wire logic        WB_STB_I,
  input  wire logic        WB_WE_I,
  input  wire logic [7:0]  WB_ADR_I,
  input  wire logic [3:0]  WB_SEL_I,
  input  wire logic [31:0] WB_DAT_I,
  output logic      [31:0] WB_DAT_O,
  output logic             WB_ACK_O,
  // Power state from the rest of the unit
  input  wire logic [1:0]  SUSPEND_MODE,
  input  wire logic        IN_SUSPEND,
  input  wire logic        CONFIGURED,
  input  wire logic        INTERNAL_PHY,
  input  wire logic        LOAD_DONE,
  input  wire logic        RESUME_DONE,
  input  wire logic        REMOTE_RESUME,
  // Wake events, one-cycle pulses
  input  wire logic        PHY_WAKE_EV,
  input  wire logic        LAN_WAKE_EV,
  input  wire logic        ENERGY_EFF_RX_WAKE_EV,
  input  wire logic        ENERGY_EFF_TX_WAKE_EV,
  // Phy side
  output logic             PHY_RESET_PIN_LOW,
  output logic             READY,
  output logic             LAN_WAKE_ENABLE,
  output logic             PHY_IRQ_WAKE_ENABLE
);
  prwk_st_t st_reg, st_next;

  logic req, wr, wr0, wr1, rclr, deep_int, held, ready_cond;
  logic [31:0] rd;

  always_comb begin
    st_next = st_reg;
    req = WB_CYC_I && WB_STB_I && !st_reg.ack;
    wr = req && WB_WE_I && (WB_ADR_I == PRWK_OFS_CTRL);
    wr0 = wr && WB_SEL_I[0];
    wr1 = wr && WB_SEL_I[1];
    rclr = RESUME_DONE && REMOTE_RESUME;
    deep_int = INTERNAL_PHY && IN_SUSPEND
               && (SUSPEND_MODE == 2'h2);
    // Wake causes: set beats a same-cycle software clear
    if (wr0 && WB_DAT_I[PRWK_BIT_CAUSE0])
      st_next.cause[0] = 1'b0;
    if ((wr0 && WB_DAT_I[PRWK_BIT_CAUSE1]) || (rclr && st_reg.clr_sts))
      st_next.cause[1] = 1'b0;
    if (wr1 && WB_DAT_I[PRWK_BIT_EEE])
      st_next.eee = 1'b0;
    if (rclr && st_reg.clr_sts)
      st_next.eee = 1'b0;
    if (PHY_WAKE_EV)
      st_next.cause[0] = 1'b1;
    if (LAN_WAKE_EV)
      st_next.cause[1] = 1'b1;
    if ((ENERGY_EFF_RX_WAKE_EV && (SUSPEND_MODE == PRWK_SUSP0
         || SUSPEND_MODE == PRWK_SUSP3))
        || (ENERGY_EFF_TX_WAKE_EV && SUSPEND_MODE == PRWK_SUSP3))
      st_next.eee = 1'b1;
    // Enables and resume controls
    if (wr0) begin
      st_next.lan_en = WB_DAT_I[PRWK_BIT_LANWK];
      st_next.phy_en = WB_DAT_I[PRWK_BIT_PHYWK];
    end
    if (rclr && st_reg.clr_en) begin
      st_next.lan_en = 1'b0;
      st_next.phy_en = 1'b0;
    end
    if (wr1) begin
      st_next.clr_en = WB_DAT_I[PRWK_BIT_CLRE];
      st_next.clr_sts = WB_DAT_I[PRWK_BIT_CLRS];
    end
    // Reset interval; writes ignored while running
    if (!st_reg.prst && wr0 && WB_DAT_I[PRWK_BIT_PRST]) begin
      st_next.prst = 1'b1;
      st_next.cnt = '0;
    end else if (st_reg.prst) begin
      if (st_reg.cnt == PRWK_CNT_W'(RST_CYC - 1))
        st_next.prst = 1'b0;
      else
        st_next.cnt = st_reg.cnt + 1'b1;
    end
    held = st_next.prst || deep_int
           || (INTERNAL_PHY && !CONFIGURED);
    st_next.pin_low = held;
    ready_cond = INTERNAL_PHY ? (CONFIGURED && !deep_int)
                              : LOAD_DONE;
    st_next.ready = !held && ready_cond && !st_reg.prst;
    // Bus answer one cycle after request
    rd = '0;
    rd[PRWK_BIT_CAUSE1:PRWK_BIT_CAUSE0] = st_reg.cause;
    rd[PRWK_BIT_PHYWK] = st_reg.phy_en;
    rd[PRWK_BIT_LANWK] = st_reg.lan_en;
    rd[PRWK_BIT_PRST] = st_reg.prst;
    rd[PRWK_BIT_READY] = st_reg.ready;
    rd[PRWK_BIT_CLRE] = st_reg.clr_en;
    rd[PRWK_BIT_CLRS] = st_reg.clr_sts;
    rd[PRWK_BIT_EEE] = st_reg.eee;
    st_next.ack = req;
    if (req && !WB_WE_I)
      st_next.dat = (WB_ADR_I == PRWK_OFS_CTRL) ? rd : 32'h0;
    if (!req)
      st_next.dat = 32'h0;
  end

  always_ff @(posedge CLK_SYS) begin
    if (SRST) begin
      st_reg <= '0;
      st_reg.clr_en <= PRWK_RST_CLRE;
      st_reg.clr_sts <= PRWK_RST_CLRS;
      st_reg.pin_low <= 1'b0;
    end else begin
      st_reg <= st_next;
    end
  end

  assign WB_DAT_O = st_reg.dat;
  assign WB_ACK_O = st_reg.ack;
  assign PHY_RESET_PIN_LOW = st_reg.pin_low;
  assign READY = st_reg.ready;
  assign LAN_WAKE_ENABLE = st_reg.lan_en;
  assign PHY_IRQ_WAKE_ENABLE = st_reg.phy_en;
endmodule
`default_nettype wire

// ### dv/prwk_ctl_props.sv
// Port assertions for the phy reset and wake control slice
`timescale 1ns/1ps
`default_nettype none
module prwk_ctl_props #(parameter int RST_CYC = 20) (
  // Observed ports
  input wire logic CLK_SYS, SRST, WB_CYC_I, WB_STB_I, WB_ACK_O, READY,
  input wire logic CONFIGURED, INTERNAL_PHY, LOAD_DONE, RESUME_DONE,
  input wire logic REMOTE_RESUME, PHY_RESET_PIN_LOW, LAN_WAKE_ENABLE,
  input wire logic PHY_IRQ_WAKE_ENABLE
);
  default clocking @(posedge CLK_SYS); endclocking
  default disable iff (SRST);
  ack_pulse_a: assert property (WB_ACK_O |=> !WB_ACK_O) else $error("ack");
  ack_resp_a: assert property (WB_CYC_I && WB_STB_I && !WB_ACK_O
    |=> WB_ACK_O) else $error("no ack");
  pin_hold_a: assert property ($rose(PHY_RESET_PIN_LOW)
    && !INTERNAL_PHY |-> PHY_RESET_PIN_LOW [*8]) else $error("pin");
  rdy_pin_a: assert property (PHY_RESET_PIN_LOW |-> !READY)
    else $error("ready");
  rdy_ext_a: assert property ($fell(PHY_RESET_PIN_LOW)
    && !INTERNAL_PHY && LOAD_DONE |=> READY) else $error("ready");
  int_pin_a: assert property (INTERNAL_PHY && !CONFIGURED
    |=> PHY_RESET_PIN_LOW) else $error("pin");
  rdy_int_a: assert property (INTERNAL_PHY && !CONFIGURED
    |=> !READY) else $error("ready");
  en_hold_a: assert property (!(WB_CYC_I
    || (RESUME_DONE && REMOTE_RESUME))
    |=> $stable({LAN_WAKE_ENABLE, PHY_IRQ_WAKE_ENABLE})) else $error("en");
  cover property (RESUME_DONE && REMOTE_RESUME);
  cover property ($fell(PHY_RESET_PIN_LOW));
  cover property (WB_ACK_O && LAN_WAKE_ENABLE);
endmodule
bind prwk_ctl prwk_ctl_props #(.RST_CYC(RST_CYC)) chk (.*);
`default_nettype wire

// ### dv/prwk_phy_mdl.sv
// External phy model: wakes only when out of reset
`timescale 1ns/1ps
`default_nettype none
module prwk_phy_mdl (
  // Clock, reset pin, stimulus and wake
  input wire logic CLK_SYS, PIN_LOW, KICK,
  output var logic WAKE
);
  initial WAKE = 1'h0;
  always @(posedge CLK_SYS) WAKE <= KICK && !PIN_LOW;
endmodule
`default_nettype wire

// ### dv/tb_prwk_ctl.sv
// Self-checking bench for the phy reset and wake control slice
`timescale 1ns/1ps
`default_nettype none
module tb_prwk_ctl;
  import prwk_pkg::*;
  logic CLK_SYS = 0, SRST = 1, WB_CYC_I = 0, WB_STB_I = 0, WB_WE_I = 0;
  logic CONFIGURED = 1, INTERNAL_PHY = 0, LOAD_DONE = 1, REMOTE_RESUME = 0;
  logic [7:0] WB_ADR_I = 0;
  logic [31:0] WB_DAT_I = 0, WB_DAT_O, q;
  logic [1:0] SUSPEND_MODE = 0;
  logic [4:0] evv = 0;
  logic WB_ACK_O, PHY_RESET_PIN_LOW, READY, LAN_WAKE_ENABLE, PHY_IRQ_WAKE_ENABLE;
  logic PHY_WAKE_EV;
  wire logic RESUME_DONE, ENERGY_EFF_TX_WAKE_EV, ENERGY_EFF_RX_WAKE_EV, LAN_WAKE_EV;
  logic IN_SUSPEND = 1'h0;
  wire logic [3:0] WB_SEL_I = 4'hf;
  int error_cnt = 0, checks_done = 0;
  assign {RESUME_DONE, ENERGY_EFF_TX_WAKE_EV, ENERGY_EFF_RX_WAKE_EV, LAN_WAKE_EV} = evv[4:1];
  always #5 CLK_SYS = ~CLK_SYS;
  prwk_ctl #(.RST_CYC(20)) uut (.*);
  prwk_phy_mdl phy (.CLK_SYS(CLK_SYS), .PIN_LOW(PHY_RESET_PIN_LOW),
    .KICK(evv[0]), .WAKE(PHY_WAKE_EV));
  task automatic chk(input logic [31:0] s, e);
    checks_done++;
    if (s !== e) begin
      error_cnt++;
      $display("ERROR %0t: saw %h want %h", $time, s, e);
    end
  endtask
  task automatic wb(input logic w, input logic [7:0] a, input logic [31:0] d);
    int i = 0;
    @(posedge CLK_SYS);
    {WB_CYC_I, WB_STB_I, WB_WE_I, WB_ADR_I, WB_DAT_I} <= {2'h3, w, a, d};
    do @(posedge CLK_SYS); while (WB_ACK_O !== 1'h1 && ++i < 50);
    // A missing answer is a failure, not a silent skip
    if (WB_ACK_O !== 1'h1)
      error_cnt++;
    q = WB_DAT_O;
    {WB_CYC_I, WB_STB_I} <= 2'h0;
  endtask
  task automatic rd(input logic [7:0] a, input logic [31:0] e);
    wb(1'h0, a, 32'h0);
    chk(q, e);
  endtask
  // Phy kick goes through the model, so allow it extra cycles
  task automatic ev(input logic [4:0] v);
    @(posedge CLK_SYS) evv <= v;
    @(posedge CLK_SYS) evv <= 5'h0;
    repeat (3) @(posedge CLK_SYS);
  endtask
  task automatic wrap_up;
    if (error_cnt == 0 && checks_done > 0)
      $display("Testbench passed");
    else
      $display("Testbench failed");
    $finish;
  endtask
  initial begin
    repeat (12) @(posedge CLK_SYS);
    SRST <= 1'h0;
    rd(8'h00, 32'h180);
    ev(5'h08);
    rd(8'h00, 32'h180);
    ev(5'h07);
    rd(8'h00, 32'h1183);
    SUSPEND_MODE <= PRWK_SUSP3;
    wb(1'h1, 8'h00, 32'h1101);
    rd(8'h00, 32'h182);
    ev(5'h08);
    rd(8'h00, 32'h1182);
    wb(1'h1, 8'h00, 32'h30c);
    ev(5'h10);
    rd(8'h00, 32'h138e);
    REMOTE_RESUME <= 1'h1;
    ev(5'h10);
    rd(8'h00, 32'h380);
    rd(8'h04, 32'h0);
    wb(1'h1, 8'h00, 32'h310);
    rd(8'h00, 32'h310);
    wb(1'h1, 8'h00, 32'h310);
    repeat (12) @(posedge CLK_SYS);
    chk(PHY_RESET_PIN_LOW, 1);
    repeat (6) @(posedge CLK_SYS);
    chk(PHY_RESET_PIN_LOW, 0);
    rd(8'h00, 32'h380);
    {INTERNAL_PHY, CONFIGURED} <= 2'h2;
    repeat (3) @(posedge CLK_SYS);
    chk({PHY_RESET_PIN_LOW, READY}, 2);
    CONFIGURED <= 1'h1;
    repeat (3) @(posedge CLK_SYS);
    chk({PHY_RESET_PIN_LOW, READY}, 1);
    {IN_SUSPEND, SUSPEND_MODE} <= 3'h6;
    repeat (3) @(posedge CLK_SYS);
    chk({PHY_RESET_PIN_LOW, READY}, 2);
    INTERNAL_PHY <= 1'h0;
    repeat (3) @(posedge CLK_SYS);
    chk({PHY_RESET_PIN_LOW, READY}, 1);
    {IN_SUSPEND, SUSPEND_MODE} <= 3'h0;
    LOAD_DONE <= 1'h0;
    repeat (3) @(posedge CLK_SYS);
    chk(READY, 0);
    LOAD_DONE <= 1'h1;
    repeat (3) @(posedge CLK_SYS);
    chk(READY, 1);
    wb(1'h1, 8'h00, 32'h310);
    rd(8'h00, 32'h310);
    wrap_up;
  end
  initial begin
    #20000;
    error_cnt++;
    wrap_up;
  end
endmodule
`default_nettype wire
